/* File: inc/port_group_regs.vh */
// Register offsets, field positions, reset values and timing counts of the port groups
`ifndef PORT_GROUP_REGS_VH
`define PORT_GROUP_REGS_VH

`define PG_ADDR_W        5
`define PG_DATA_W        16
`define PG_PINS          8
`define PG_GROUPS        2

`define PG_GROUP_BIT     3
`define PG_GROUP0_BASE   5'h00
`define PG_GROUP1_BASE   5'h08

`define PG_REG_DATA      3'h0
`define PG_REG_IOEN      3'h1
`define PG_REG_PULL      3'h2
`define PG_REG_FLAGS     3'h3
`define PG_REG_IRQCTL    3'h4
`define PG_REG_DEBOUNCE  3'h5
`define PG_REG_MODE      3'h6
`define PG_REG_FUNC      3'h7

`define PG_HI_MSB        15
`define PG_HI_LSB        8
`define PG_LO_MSB        7
`define PG_LO_LSB        0

`define PG_RESET_VALUE   16'h0000
`define PG_BYTE_ZERO     8'h00

`define PG_FUNC_GLUE     2'h0
`define PG_FUNC_ROUTER   2'h1
`define PG_FUNC_ALT2     2'h2
`define PG_FUNC_ALT3     2'h3

`define PG_G0_AVAIL_F0   8'hFF
`define PG_G0_AVAIL_F1   8'hFF
`define PG_G0_AVAIL_F2   8'h00
`define PG_G0_AVAIL_F3   8'h00
`define PG_G1_AVAIL_F0   8'hBF
`define PG_G1_AVAIL_F1   8'hFF
`define PG_G1_AVAIL_F2   8'h04
`define PG_G1_AVAIL_F3   8'hF8

`define PG_CLK_PERIOD_NS 10
`define PG_DEB_SAMPLE_NS 160
`define PG_DEB_DIV       (`PG_DEB_SAMPLE_NS / `PG_CLK_PERIOD_NS)

`endif

/* File: rtl/port_group.v */
// Two eight-pin port groups: registers, pin routing, debounce and edge interrupts
//
// Behaviour
// - Group zero: eight GPIO pins with interrupts
// - Group one: same GPIO and interrupt set
// - Flags low byte, write one clears
// - Mode bit: zero GPIO, one peripheral
// - Irq control: edge high, enable low
// - Pull control: direction high, enable low
// - Group zero codes zero and one routing
// - Group zero codes two, three unassigned
// - Group one code zero routing except pin six, code one routing
// - Group one code two routing pin two only, code three pins three to seven
// - Function code acts only in peripheral mode
// - Debounce bit one filters, zero bypasses
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "port_group_regs.vh"

module port_group #(
  parameter DEB_DIV = `PG_DEB_DIV
) (
  input  wire                   clk,
  input  wire                   resetn,
  input  wire [`PG_ADDR_W-1:0]  regAddr,
  input  wire [`PG_DATA_W-1:0]  regWdata,
  input  wire                   regWr,
  input  wire                   regRd,
  output reg  [`PG_DATA_W-1:0]  regRdata,
  output reg                    irq,
  input  wire [15:0]            padIn,
  output reg  [15:0]            padOut,
  output reg  [15:0]            padOe,
  output reg  [15:0]            padPullOn,
  output reg  [15:0]            padPullDir,
  input  wire [15:0]            fn0Out,
  input  wire [15:0]            fn0Oe,
  input  wire [15:0]            fn1Out,
  input  wire [15:0]            fn1Oe,
  input  wire [15:0]            fn2Out,
  input  wire [15:0]            fn2Oe,
  input  wire [15:0]            fn3Out,
  input  wire [15:0]            fn3Oe,
  output reg  [15:0]            fn0In,
  output reg  [15:0]            fn1In,
  output reg  [15:0]            fn2In,
  output reg  [15:0]            fn3In
);

  localparam NPINS = `PG_PINS * `PG_GROUPS;

  reg  [15:0] outVal_q;
  reg  [15:0] inBufOn_q;
  reg  [15:0] drvOn_q;
  reg  [15:0] pullDir_q;
  reg  [15:0] pullOn_q;
  reg  [15:0] flag_q;
  reg  [15:0] edge_q;
  reg  [15:0] irqEn_q;
  reg  [15:0] debOn_q;
  reg  [15:0] mode_q;
  reg  [31:0] func_q;
  reg  [15:0] sync1_q;
  reg  [15:0] sync2_q;
  reg  [15:0] samp_q;
  reg  [15:0] filt_q;
  reg  [15:0] level_q;
  reg  [15:0] prevLevel_q;
  reg  [15:0] divCnt_q;
  reg  [15:0] divCnt_d;
  reg         tick_q;

  wire [15:0] availF0 = {`PG_G1_AVAIL_F0, `PG_G0_AVAIL_F0};
  wire [15:0] availF1 = {`PG_G1_AVAIL_F1, `PG_G0_AVAIL_F1};
  wire [15:0] availF2 = {`PG_G1_AVAIL_F2, `PG_G0_AVAIL_F2};
  wire [15:0] availF3 = {`PG_G1_AVAIL_F3, `PG_G0_AVAIL_F3};

  wire        grp    = regAddr[`PG_GROUP_BIT];
  wire        mapped = (regAddr[`PG_ADDR_W-1:`PG_GROUP_BIT+1] == 1'b0);
  wire [2:0]  sel    = regAddr[2:0];
  wire        wrHit  = regWr & mapped;
  wire [15:0] inLevel = level_q & inBufOn_q;

  // Debounce sample tick; filter time trades pin latency against noise rejection
  always @*
  begin
    divCnt_d = divCnt_q + 16'h0001;
    if (divCnt_q >= DEB_DIV[15:0] - 16'h0001)
    begin
      divCnt_d = 16'h0000;
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      divCnt_q <= 16'h0000;
      tick_q   <= 1'b0;
    end
    else
    begin
      divCnt_q <= divCnt_d;
      tick_q   <= (divCnt_d == 16'h0000);
    end
  end

  // Register writes, one group selected by the address
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      outVal_q  <= `PG_RESET_VALUE;
      inBufOn_q <= `PG_RESET_VALUE;
      drvOn_q   <= `PG_RESET_VALUE;
      pullDir_q <= `PG_RESET_VALUE;
      pullOn_q  <= `PG_RESET_VALUE;
      edge_q    <= `PG_RESET_VALUE;
      irqEn_q   <= `PG_RESET_VALUE;
      debOn_q   <= `PG_RESET_VALUE;
      mode_q    <= `PG_RESET_VALUE;
      func_q    <= 32'h00000000;
    end
    else if (wrHit)
    begin
      case (sel)
        `PG_REG_DATA:
        begin
          // Low byte is the pin level view; writes there are dropped
          if (grp)
          begin
            outVal_q[15:8] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
          end
          else
          begin
            outVal_q[7:0] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
          end
        end
        `PG_REG_IOEN:
        begin
          if (grp)
          begin
            inBufOn_q[15:8] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            drvOn_q[15:8]   <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
          else
          begin
            inBufOn_q[7:0] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            drvOn_q[7:0]   <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
        end
        `PG_REG_PULL:
        begin
          if (grp)
          begin
            pullDir_q[15:8] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            pullOn_q[15:8]  <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
          else
          begin
            pullDir_q[7:0] <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            pullOn_q[7:0]  <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
        end
        `PG_REG_IRQCTL:
        begin
          if (grp)
          begin
            edge_q[15:8]  <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            irqEn_q[15:8] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
          else
          begin
            edge_q[7:0]  <= regWdata[`PG_HI_MSB:`PG_HI_LSB];
            irqEn_q[7:0] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
        end
        `PG_REG_DEBOUNCE:
        begin
          if (grp)
          begin
            debOn_q[15:8] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
          else
          begin
            debOn_q[7:0] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
        end
        `PG_REG_MODE:
        begin
          if (grp)
          begin
            mode_q[15:8] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
          else
          begin
            mode_q[7:0] <= regWdata[`PG_LO_MSB:`PG_LO_LSB];
          end
        end
        `PG_REG_FUNC:
        begin
          // Pin y owns code bits 2y+1:2y of its group's half
          if (grp)
          begin
            func_q[31:16] <= regWdata;
          end
          else
          begin
            func_q[15:0] <= regWdata;
          end
        end
        default:
        begin
          outVal_q <= outVal_q;
        end
      endcase
    end
  end

  // Per-pin input path, edge flags and routing; both groups share one structure
  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1)
    begin : pin
      wire [1:0] code   = func_q[2*i+1:2*i];
      wire       isPeri = mode_q[i];
      wire       rise   = level_q[i] & ~prevLevel_q[i];
      wire       fall   = ~level_q[i] & prevLevel_q[i];
      wire       hit    = irqEn_q[i] & (edge_q[i] ? fall : rise);
      wire       clrHit = wrHit & (sel == `PG_REG_FLAGS) & (grp == (i >= `PG_PINS))
                          & regWdata[i % `PG_PINS];
      wire       av0    = availF0[i];
      wire       av1    = availF1[i];
      wire       av2    = availF2[i];
      wire       av3    = availF3[i];

      // First stage feeds only the second; the filter needs two equal samples on successive ticks
      always @(posedge clk)
      begin
        if (!resetn)
        begin
          sync1_q[i]     <= 1'b0;
          sync2_q[i]     <= 1'b0;
          samp_q[i]      <= 1'b0;
          filt_q[i]      <= 1'b0;
          level_q[i]     <= 1'b0;
          prevLevel_q[i] <= 1'b0;
          flag_q[i]      <= 1'b0;
        end
        else
        begin
          sync1_q[i] <= padIn[i];
          sync2_q[i] <= sync1_q[i];
          if (tick_q)
          begin
            samp_q[i] <= sync2_q[i];
            if (samp_q[i] == sync2_q[i])
            begin
              filt_q[i] <= samp_q[i];
            end
          end
          level_q[i]     <= debOn_q[i] ? filt_q[i] : sync2_q[i];
          prevLevel_q[i] <= level_q[i];
          // A new edge beats a clear in the same cycle
          flag_q[i]      <= hit | (flag_q[i] & ~clrHit);
        end
      end

      // Pad drive and peripheral input routing, all registered
      always @(posedge clk)
      begin
        if (!resetn)
        begin
          padOut[i]     <= 1'b0;
          padOe[i]      <= 1'b0;
          padPullOn[i]  <= 1'b0;
          padPullDir[i] <= 1'b0;
          fn0In[i]      <= 1'b0;
          fn1In[i]      <= 1'b0;
          fn2In[i]      <= 1'b0;
          fn3In[i]      <= 1'b0;
        end
        else
        begin
          padPullOn[i]  <= pullOn_q[i];
          padPullDir[i] <= pullDir_q[i];
          if (!isPeri)
          begin
            padOut[i] <= outVal_q[i];
            padOe[i]  <= drvOn_q[i];
          end
          else
          begin
            // Unassigned codes leave the pad low and undriven
            case (code)
              `PG_FUNC_GLUE:
              begin
                padOut[i] <= av0 & fn0Out[i];
                padOe[i]  <= av0 & fn0Oe[i];
              end
              `PG_FUNC_ROUTER:
              begin
                padOut[i] <= av1 & fn1Out[i];
                padOe[i]  <= av1 & fn1Oe[i];
              end
              `PG_FUNC_ALT2:
              begin
                padOut[i] <= av2 & fn2Out[i];
                padOe[i]  <= av2 & fn2Oe[i];
              end
              default:
              begin
                padOut[i] <= av3 & fn3Out[i];
                padOe[i]  <= av3 & fn3Oe[i];
              end
            endcase
          end
          // Unselected or unassigned functions see a quiet low input
          fn0In[i] <= isPeri & (code == `PG_FUNC_GLUE) & av0 & level_q[i];
          fn1In[i] <= isPeri & (code == `PG_FUNC_ROUTER) & av1 & level_q[i];
          fn2In[i] <= isPeri & (code == `PG_FUNC_ALT2) & av2 & level_q[i];
          fn3In[i] <= isPeri & (code == `PG_FUNC_ALT3) & av3 & level_q[i];
        end
      end
    end
  endgenerate

  // Read data one cycle after the strobe; unmapped and idle cycles read zero
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      regRdata <= `PG_RESET_VALUE;
      irq      <= 1'b0;
    end
    else
    begin
      irq <= |(flag_q & irqEn_q);
      regRdata <= `PG_RESET_VALUE;
      if (regRd && mapped)
      begin
        case (sel)
          `PG_REG_DATA:
            regRdata <= grp ? {outVal_q[15:8], inLevel[15:8]}
                            : {outVal_q[7:0], inLevel[7:0]};
          `PG_REG_IOEN:
            regRdata <= grp ? {inBufOn_q[15:8], drvOn_q[15:8]}
                            : {inBufOn_q[7:0], drvOn_q[7:0]};
          `PG_REG_PULL:
            regRdata <= grp ? {pullDir_q[15:8], pullOn_q[15:8]}
                            : {pullDir_q[7:0], pullOn_q[7:0]};
          `PG_REG_FLAGS:
            regRdata <= grp ? {`PG_BYTE_ZERO, flag_q[15:8]}
                            : {`PG_BYTE_ZERO, flag_q[7:0]};
          `PG_REG_IRQCTL:
            regRdata <= grp ? {edge_q[15:8], irqEn_q[15:8]}
                            : {edge_q[7:0], irqEn_q[7:0]};
          `PG_REG_DEBOUNCE:
            regRdata <= grp ? {`PG_BYTE_ZERO, debOn_q[15:8]}
                            : {`PG_BYTE_ZERO, debOn_q[7:0]};
          `PG_REG_MODE:
            regRdata <= grp ? {`PG_BYTE_ZERO, mode_q[15:8]}
                            : {`PG_BYTE_ZERO, mode_q[7:0]};
          // Function register: every pin's code bits read back
          default:
            regRdata <= grp ? func_q[31:16] : func_q[15:0];
        endcase
      end
    end
  end

endmodule

/* File: dv/port_group_checker.sv */
// Port-level checks for the port groups, bound to the design
`timescale 1ns/1ps
`include "port_group_regs.vh"
module port_group_checker #(
  parameter DEB_DIV = 2
) (
  input wire                  clk,
  input wire                  resetn,
  input wire [`PG_ADDR_W-1:0] regAddr,
  input wire                  regWr,
  input wire                  regRd,
  input wire [15:0]           regRdata,
  input wire                  irq,
  input wire [15:0]           padPullOn,
  input wire [15:0]           padPullDir,
  input wire [15:0]           fn0In,
  input wire [15:0]           fn1In,
  input wire [15:0]           fn2In,
  input wire [15:0]           fn3In
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data not idle");
  chk_unmapped_read: assert property (regRd && regAddr[4] |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_flags_upper: assert property (regRd && regAddr[2:0] == `PG_REG_FLAGS |=>
    regRdata[15:8] == 8'h00) else $error("flag upper byte set");
  chk_mode_upper: assert property (regRd && regAddr[2:0] == `PG_REG_MODE |=>
    regRdata[15:8] == 8'h00) else $error("mode upper byte set");
  chk_filter_upper: assert property (regRd && regAddr[2:0] == `PG_REG_DEBOUNCE |=>
    regRdata[15:8] == 8'h00) else $error("filter upper byte set");
  // Interrupt drops only after a flag clear or a mask write
  chk_irq_release: assert property ($fell(irq) |-> $past(regWr) || $past(regWr, 2))
    else $error("irq fell without a write");
  chk_g0_unassigned: assert property (fn2In[7:0] == 8'h00 && fn3In[7:0] == 8'h00)
    else $error("group zero unassigned input active");
  chk_g1_unassigned: assert property (fn0In[14] == 1'b0 && fn2In[15:11] == 5'h00 &&
    fn2In[9:8] == 2'h0 && fn3In[10:8] == 3'h0) else $error("group one unassigned input active");
  chk_one_function: assert property (((fn0In & fn1In) | (fn2In & fn3In) |
    ((fn0In | fn1In) & (fn2In | fn3In))) == 16'h0000) else $error("two functions on a pin");
  chk_pull_steady: assert property (!$past(regWr) && !$past(regWr, 2) |->
    $stable(padPullOn) && $stable(padPullDir)) else $error("pull outputs moved");
endmodule

bind port_group port_group_checker #(.DEB_DIV(DEB_DIV)) port_group_checker_inst (.clk, .resetn,
  .regAddr, .regWr, .regRd, .regRdata, .irq, .padPullOn, .padPullDir, .fn0In, .fn1In, .fn2In,
  .fn3In);

/* File: dv/peripheral_model.sv */
// Peripheral side: each function code drives a distinct pattern of one base word
`timescale 1ns/1ps
module peripheral_model (
  input  wire [15:0] pattern,
  output wire [15:0] fn0Out,
  output wire [15:0] fn0Oe,
  output wire [15:0] fn1Out,
  output wire [15:0] fn1Oe,
  output wire [15:0] fn2Out,
  output wire [15:0] fn2Oe,
  output wire [15:0] fn3Out,
  output wire [15:0] fn3Oe
);
  // Distinct per code so a wrong route cannot match by chance
  assign fn0Out = pattern;
  assign fn1Out = ~pattern;
  assign fn2Out = {pattern[7:0], pattern[15:8]};
  assign fn3Out = pattern ^ 16'h0F0F;
  assign fn0Oe  = ~fn0Out;
  assign fn1Oe  = ~fn1Out;
  assign fn2Oe  = ~fn2Out;
  assign fn3Oe  = ~fn3Out;
endmodule

/* File: dv/test_port_group.sv */
// Self-checking bench for the port groups: registers, pins, interrupts, filter, routing
`timescale 1ns/1ps
`include "port_group_regs.vh"
module test_port_group;
  reg        clk = 1'b0;
  reg        resetn = 1'b0;
  reg  [4:0] regAddr = 5'h00;
  reg [15:0] regWdata = 16'h0000;
  reg        regWr = 1'b0;
  reg        regRd = 1'b0;
  reg [15:0] padIn = 16'h0000;
  reg [15:0] pattern = 16'h6B2D;
  wire       irq;
  wire [15:0] regRdata, padOut, padOe, padPullOn, padPullDir, fn0In, fn1In, fn2In, fn3In;
  wire [15:0] fn0Out, fn1Out, fn2Out, fn3Out, fn0Oe, fn1Oe, fn2Oe, fn3Oe;
  integer    numErrors = 0, nTests = 0, cyc = 0, g, k, r;
  reg [15:0] msk [0:7] = '{16'hFF00, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h00FF,
                           16'h00FF, 16'hFFFF};
  reg  [7:0] avt [0:7] = '{`PG_G0_AVAIL_F0, `PG_G0_AVAIL_F1, `PG_G0_AVAIL_F2, `PG_G0_AVAIL_F3,
                           `PG_G1_AVAIL_F0, `PG_G1_AVAIL_F1, `PG_G1_AVAIL_F2, `PG_G1_AVAIL_F3};
  always #5 clk = ~clk;
  port_group #(.DEB_DIV(2)) port_group_inst (.clk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .irq, .padIn, .padOut, .padOe, .padPullOn, .padPullDir, .fn0Out, .fn0Oe, .fn1Out,
    .fn1Oe, .fn2Out, .fn2Oe, .fn3Out, .fn3Oe, .fn0In, .fn1In, .fn2In, .fn3In);
  peripheral_model peripheral_model_inst (.pattern, .fn0Out, .fn0Oe, .fn1Out, .fn1Oe, .fn2Out,
    .fn2Oe, .fn3Out, .fn3Oe);
  function automatic [15:0] pick(input integer n, input [15:0] a, b, c, d);
    pick = n == 0 ? a : n == 1 ? b : n == 2 ? c : d;
  endfunction
  function automatic [15:0] grp(input integer n, input [15:0] v);
    grp = n ? {8'h00, v[15:8]} : {8'h00, v[7:0]};
  endfunction
  task check(input [15:0] got, input [15:0] exp);
    nTests = nTests + 1;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      numErrors = numErrors + 1;
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input [4:0] a, input [15:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask
  task reportAndStop;
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is well under two thousand cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      numErrors = numErrors + 1;
      reportAndStop;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (g = 0; g < 16; g = g + 1)
      rd(g[4:0], 16'h0000);
    for (g = 0; g < 16; g = g + 1)
    begin
      wr(g[4:0], 16'hFFFF);
      rd(g[4:0], msk[g % 8]);
      wr(g[4:0], 16'h0000);
    end
    wr(5'h10, 16'hFFFF);
    rd(5'h10, 16'h0000);
    $display("test registers done");
    @(posedge clk) padIn <= 16'h5AC3;
    wr(5'h01, 16'hFFFF);
    wr(5'h00, 16'hA5FF);
    wr(5'h09, 16'h00FF);
    wr(5'h02, 16'h0F33);
    repeat (3) @(posedge clk);
    #1 check(padOe, 16'hFFFF);
    check(padOut, 16'h00A5);
    check({padPullDir[7:0], padPullOn[7:0]}, 16'h0F33);
    rd(5'h00, 16'hA5C3);
    rd(5'h08, 16'h0000);
    $display("test pins done");
    wr(5'h04, 16'h0001);
    @(posedge clk) padIn[0] <= 1'b0;
    repeat (8) @(posedge clk);
    rd(5'h03, 16'h0000);
    @(posedge clk) padIn[1:0] <= 2'b01;
    repeat (8) @(posedge clk);
    #1 check({15'h0000, irq}, 16'h0001);
    wr(5'h03, 16'h00FE);
    rd(5'h03, 16'h0001);
    wr(5'h03, 16'h0001);
    rd(5'h03, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wr(5'h0C, 16'h0202);
    @(posedge clk) padIn[9] <= 1'b0;
    repeat (8) @(posedge clk);
    rd(5'h0B, 16'h0002);
    wr(5'h0C, 16'h0200);
    rd(5'h0B, 16'h0002);
    check({15'h0000, irq}, 16'h0000);
    wr(5'h0B, 16'h0002);
    $display("test interrupts done");
    wr(5'h0C, 16'h0002);
    wr(5'h0D, 16'h0002);
    @(posedge clk) padIn[9] <= 1'b1;
    @(posedge clk) padIn[9] <= 1'b0;
    repeat (12) @(posedge clk);
    rd(5'h0B, 16'h0000);
    @(posedge clk) padIn[9] <= 1'b1;
    repeat (12) @(posedge clk);
    rd(5'h0B, 16'h0002);
    wr(5'h0B, 16'h0002);
    $display("test filter done");
    @(posedge clk) padIn <= 16'h3C96;
    for (g = 0; g < 2; g = g + 1)
    begin
      wr({g[1:0], 3'h6}, 16'h00FF);
      for (k = 0; k < 4; k = k + 1)
      begin
        wr({g[1:0], 3'h7}, {8{k[1:0]}});
        repeat (10) @(posedge clk);
        #1;
        for (r = 0; r < 4; r = r + 1)
          check(grp(g, pick(r, fn0In, fn1In, fn2In, fn3In)),
            r == k ? grp(g, padIn) & avt[g * 4 + k] : 16'h0000);
        check(grp(g, padOut),
          grp(g, pick(k, fn0Out, fn1Out, fn2Out, fn3Out)) & avt[g * 4 + k]);
        check(grp(g, padOe),
          grp(g, pick(k, fn0Oe, fn1Oe, fn2Oe, fn3Oe)) & avt[g * 4 + k]);
      end
      wr({g[1:0], 3'h6}, 16'h0000);
      repeat (4) @(posedge clk);
      #1 check(grp(g, fn0In | fn1In | fn2In | fn3In), 16'h0000);
      check(grp(g, padOut), g ? 16'h0000 : 16'h00A5);
    end
    $display("test routing done");
    reportAndStop;
  end
endmodule
